// *** verilog/sac_top.v ***
// successive-approximation converter control with apb register slave
`timescale 1ns/10ps
`include "sac_defs.vh"

module sac_top #(
    parameter RES_W = 8,
    parameter CHAN_N = 4
)(
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SAC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire low_power,
    input wire cmp_in,
    output reg [RES_W-1:0] dac_code,
    output reg ladder_connect,
    output reg [CHAN_N-1:0] chan_enable,
    output reg conversion_done_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg trig_q;
    reg analog_input_disable_q;
    reg [1:0] fix_q;
    reg [3:0] sel_q;
    reg [5:0] c2_q;
    reg busy_q;
    reg done_q;
    reg sar_on_q;
    reg [2:0] bit_q;
    reg [RES_W-1:0] result_q;
    reg [`SAC_CNT_W-1:0] tot_q;
    reg [`SAC_CNT_W-1:0] step_q;
    reg [`SAC_CNT_W-1:0] len_q;
    reg [`SAC_CNT_W-1:0] sl_q;
    reg cmp_s1_q;
    reg cmp_s2_q;

    wire [`SAC_ADDR_W-1:0] a_c1 = {2'b00, `SAC_IDX_CTRL1, 2'b00};
    wire [`SAC_ADDR_W-1:0] a_c2 = {2'b00, `SAC_IDX_CTRL2, 2'b00};
    wire [`SAC_ADDR_W-1:0] a_res = {2'b00, `SAC_IDX_RESULT, 2'b00};
    wire [`SAC_ADDR_W-1:0] a_st = {2'b00, `SAC_IDX_STATUS, 2'b00};

    // first control reset image, split into fields below
    localparam [7:0] C1_RST = `SAC_C1_RESET;

    // ------------------------------------------------------------
    // conversion length per time code
    // ------------------------------------------------------------
    // time code decode
    function [`SAC_CNT_W-1:0] conv_len;
        input [2:0] code;
        begin
            case (code)
                3'b000: conv_len = `SAC_FC_000 * `SAC_FC_PER_CYCLE;
                3'b010: conv_len = `SAC_FC_010 * `SAC_FC_PER_CYCLE;
                3'b011: conv_len = `SAC_FC_011 * `SAC_FC_PER_CYCLE;
                3'b100: conv_len = `SAC_FC_100 * `SAC_FC_PER_CYCLE;
                3'b101: conv_len = `SAC_FC_101 * `SAC_FC_PER_CYCLE;
                3'b110: conv_len = `SAC_FC_110 * `SAC_FC_PER_CYCLE;
                default: conv_len = {`SAC_CNT_W{1'b0}};
            endcase
        end
    endfunction

    wire [`SAC_CNT_W-1:0] sel_len = conv_len(c2_q[`SAC_C2_TIME_HI:`SAC_C2_TIME_LO]);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup = psel && !penable;
    wire acc = psel && penable && pready;
    wire hit = (paddr == a_c1) || (paddr == a_c2) || (paddr == a_res) || (paddr == a_st);
    wire wr_c1 = acc && pwrite && (paddr == a_c1) && !low_power;
    wire wr_c2 = acc && pwrite && (paddr == a_c2) && !low_power;
    wire rd_res = acc && !pwrite && (paddr == a_res);

    // start only when idle and enabled
    wire start = trig_q && !busy_q && !analog_input_disable_q && (sel_len != {`SAC_CNT_W{1'b0}}) && !low_power;
    wire step_end = busy_q && sar_on_q && (step_q == sl_q);
    wire finish = busy_q && !low_power && (tot_q == len_q - `SAC_CNT_W'd1);

    reg [7:0] rd_mux;

    // read mux; unused high bits read as zero
    always @*
    begin
        rd_mux = 8'h00;
        if (paddr == a_c1)
            rd_mux = {trig_q, fix_q, analog_input_disable_q, sel_q};
        else if (paddr == a_c2)
            // bits 7 and 6 read as zero here
            rd_mux = {2'b00, c2_q};
        else if (paddr == a_res)
            rd_mux = result_q;
        else if (paddr == a_st)
            rd_mux = {2'b00, done_q, busy_q, 4'h0};
    end

    // ------------------------------------------------------------
    // apb answer: one wait-free access, data set during setup
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !hit;
            prdata <= (setup && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // low power forces initial values
    always @(posedge sys_clk)
    begin
        if (rst || low_power)
        begin
            trig_q <= C1_RST[`SAC_C1_TRIG];
            fix_q <= C1_RST[`SAC_C1_FIX_HI:`SAC_C1_FIX_LO];
            analog_input_disable_q <= C1_RST[`SAC_C1_ANALOG_INPUT_DISABLE];
            sel_q <= C1_RST[`SAC_C1_SEL_HI:`SAC_C1_SEL_LO];
            c2_q <= `SAC_C2_RESET;
        end
        else
        begin
            if (wr_c1)
            begin
                trig_q <= pwdata[`SAC_C1_TRIG];
                fix_q <= pwdata[`SAC_C1_FIX_HI:`SAC_C1_FIX_LO];
                analog_input_disable_q <= pwdata[`SAC_C1_ANALOG_INPUT_DISABLE];
                sel_q <= pwdata[`SAC_C1_SEL_HI:`SAC_C1_SEL_LO];
            end
            else
            begin
                trig_q <= 1'b0;
            end
            if (wr_c2)
                c2_q <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // comparator synchroniser; analog result is asynchronous
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            cmp_s1_q <= cmp_in;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    // step length leaves slack so the last decision lands before finish
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            sar_on_q <= 1'b0;
            bit_q <= 3'd7;
            dac_code <= {RES_W{1'b0}};
            tot_q <= {`SAC_CNT_W{1'b0}};
            step_q <= {`SAC_CNT_W{1'b0}};
            len_q <= {`SAC_CNT_W{1'b0}};
            sl_q <= {`SAC_CNT_W{1'b0}};
            result_q <= {RES_W{1'b0}};
        end
        else if (low_power)
        begin
            // low power aborts and clears busy
            busy_q <= 1'b0;
            sar_on_q <= 1'b0;
        end
        else if (start)
        begin
            busy_q <= 1'b1;
            sar_on_q <= 1'b1;
            bit_q <= 3'd7;
            dac_code <= {1'b1, {(RES_W-1){1'b0}}};
            tot_q <= {`SAC_CNT_W{1'b0}};
            step_q <= {`SAC_CNT_W{1'b0}};
            len_q <= sel_len;
            sl_q <= ((sel_len - `SAC_CNT_W'd1) >> 3) - `SAC_CNT_W'd1;
        end
        else if (busy_q)
        begin
            tot_q <= tot_q + `SAC_CNT_W'd1;
            if (step_end)
            begin
                // keep bit if input is at or above ladder
                step_q <= {`SAC_CNT_W{1'b0}};
                dac_code[bit_q] <= cmp_s2_q;
                if (bit_q != 3'd0)
                    dac_code[bit_q - 3'd1] <= 1'b1;
                else
                    sar_on_q <= 1'b0;
                bit_q <= bit_q - 3'd1;
            end
            else if (sar_on_q)
            begin
                step_q <= step_q + `SAC_CNT_W'd1;
            end
            if (finish)
            begin
                busy_q <= 1'b0;
                result_q <= dac_code;
            end
        end
    end

    // ------------------------------------------------------------
    // done flag and completion pulse
    // ------------------------------------------------------------
    // set wins over a read in the same cycle, so no event is lost
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            conversion_done_irq <= 1'b0;
        end
        else
        begin
            conversion_done_irq <= finish;
            if (finish)
                done_q <= 1'b1;
            // cleared by result read or restart
            else if (rd_res || start)
                done_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // analog steering outputs
    // ------------------------------------------------------------
    // ladder during conversion or always
    always @(posedge sys_clk)
    begin
        if (rst)
            ladder_connect <= 1'b0;
        else
            ladder_connect <= c2_q[`SAC_C2_LADDER] || busy_q;
    end

    wire [CHAN_N-1:0] chan_d;

    genvar gi;
    generate
        for (gi = 0; gi < CHAN_N; gi = gi + 1)
        begin : g_chan
            localparam [31:0] CODE = gi + 1;
            // codes 1..4 route inputs; disable gates all
            assign chan_d[gi] = !analog_input_disable_q && (sel_q == CODE[3:0]);
        end
    endgenerate

    // one register for all inputs keeps a single driver
    always @(posedge sys_clk)
    begin
        if (rst)
            chan_enable <= {CHAN_N{1'b0}};
        else
            chan_enable <= chan_d;
    end

endmodule

// *** verilog/sac_defs.vh ***
// register map, field positions, reset values and conversion timing of the sar converter
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// ------------------------------------------------------------
// register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define SAC_IDX_CTRL1 8'h0e
`define SAC_IDX_CTRL2 8'h0f
`define SAC_IDX_RESULT 8'h1f
`define SAC_IDX_STATUS 8'h20
`define SAC_ADDR_W 12

// ------------------------------------------------------------
// first control register fields
// ------------------------------------------------------------
`define SAC_C1_TRIG 7
`define SAC_C1_FIX_HI 6
`define SAC_C1_FIX_LO 5
`define SAC_C1_ANALOG_INPUT_DISABLE 4
`define SAC_C1_SEL_HI 3
`define SAC_C1_SEL_LO 0
`define SAC_C1_RESET 8'h10

// ------------------------------------------------------------
// second control register fields
// ------------------------------------------------------------
`define SAC_C2_LADDER 5
`define SAC_C2_TIME_HI 3
`define SAC_C2_TIME_LO 1
`define SAC_C2_RESET 6'h00

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define SAC_ST_DONE 5
`define SAC_ST_BUSY 4

// ------------------------------------------------------------
// conversion time in fc periods; fc is sys_clk, so periods are cycles
// ------------------------------------------------------------
`define SAC_FC_000 11'd39
`define SAC_FC_010 11'd78
`define SAC_FC_011 11'd156
`define SAC_FC_100 11'd312
`define SAC_FC_101 11'd624
`define SAC_FC_110 11'd1248
`define SAC_FC_PER_CYCLE 11'd1
`define SAC_CNT_W 11

`endif

// *** verification/sac_top_props.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/10ps
// --------------------------------
// port checker
// --------------------------------
module sac_top_props #(
    parameter RES_W = 8,
    parameter CHAN_N = 4
)(
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire low_power,
    input wire cmp_in,
    input wire [RES_W-1:0] dac_code,
    input wire ladder_connect,
    input wire [CHAN_N-1:0] chan_enable,
    input wire conversion_done_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_lp_hold;
        low_power [*3];
    endsequence
    property p_rdy;
        s_setup |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
    property p_rdy_cause;
        !(psel && !penable) |=> !pready;
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("pready without setup");
    property p_err;
        s_setup ##0 !(paddr inside {12'h038, 12'h03c, 12'h07c, 12'h080}) |=> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access without error");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error answer malformed");
    property p_upper;
        prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_irq;
        conversion_done_irq |=> !conversion_done_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq longer than one cycle");
    property p_chan;
        $onehot0(chan_enable);
    endproperty
    a_chan: assert property (p_chan) else $error("more than one input routed");
    property p_lp;
        s_lp_hold |-> chan_enable == 4'h0 && !ladder_connect && !conversion_done_irq;
    endproperty
    a_lp: assert property (p_lp) else $error("low power left converter active");
endmodule

// *** verification/sac_analog_src.sv ***
// analog sources on four inputs feeding the comparator
`timescale 1ns/10ps
module sac_analog_src (
    input wire sys_clk,
    input wire [7:0] dac_code,
    input wire [3:0] chan_enable,
    input wire ladder_connect,
    input wire [31:0] levels,
    output reg cmp_in
);
    reg junk_q = 1'b0;
    reg [7:0] sel;
    // open input gives a toggling pattern, never a stale level
    always @(posedge sys_clk)
        junk_q <= ~junk_q;
    always @*
    begin
        sel = chan_enable[0] ? levels[7:0] : chan_enable[1] ? levels[15:8] :
            chan_enable[2] ? levels[23:16] : levels[31:24];
        cmp_in = (chan_enable != 4'h0 && ladder_connect) ? (sel >= dac_code) : junk_q;
    end
endmodule

// *** verification/sac_top_tb.sv ***
// register level test of the converter control
`timescale 1ns/10ps
module sac_top_tb;
    reg sys_clk, rst, psel, penable, pwrite, low_power;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, cmp_in, ladder_connect, conversion_done_irq;
    wire [7:0] dac_code;
    wire [3:0] chan_enable;
    reg [31:0] levels = 32'hff00a55a;
    integer bad_count = 0, n_compared = 0, i, n, ch;
    reg [7:0] d;
    reg e, lad;
    sac_top u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_power(low_power), .cmp_in(cmp_in), .dac_code(dac_code),
        .ladder_connect(ladder_connect), .chan_enable(chan_enable),
        .conversion_done_irq(conversion_done_irq));
    sac_analog_src u_src (.sys_clk(sys_clk), .dac_code(dac_code), .chan_enable(chan_enable),
        .ladder_connect(ladder_connect), .levels(levels), .cmp_in(cmp_in));
    initial
    begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    task results;
    begin
        $display("checks=%0d errors=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // apb transfer; request held until pready seen at an edge
    task apb(input w, input [11:0] a, input [7:0] wd);
    begin
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        // only the watchdog ends a wait
        while (pready !== 1'b1)
            @(posedge sys_clk);
        d = prdata[7:0];
        e = pslverr;
        psel <= 0; penable <= 0;
    end
    endtask
    task rd(input [11:0] a, input [7:0] exp, input [7:0] m);
    begin
        apb(0, a, 8'h00);
        chk(d & m, exp);
    end
    endtask
    // cycles from the trigger write to the irq pulse, 0 if none
    task wait_irq(input integer lim);
        integer k;
    begin
        n = 0; lad = 0;
        for (k = 1; k <= lim && n == 0; k = k + 1)
        begin
            @(posedge sys_clk);
            #1;
            lad = lad | ladder_connect;
            if (conversion_done_irq === 1'b1)
                n = k;
        end
    end
    endtask
    initial
    begin
        #(20000 * 50);
        bad_count = bad_count + 1;
        results;
    end
    initial
    begin
        rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; low_power = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        rd(12'h038, 8'h10, 8'hff);
        rd(12'h03c, 8'h00, 8'h3f);
        rd(12'h080, 8'h00, 8'hff);
        apb(0, 12'h040, 8'h00);
        chk(e, 1);
        // every legal time code, channels rotating
        for (i = 0; i < 6; i = i + 1)
        begin
            ch = i % 4 + 1;
            apb(1, 12'h03c, 8'h10 | ((i == 0 ? 0 : i + 1) << 1));
            apb(1, 12'h038, 8'h20 | ch);
            apb(1, 12'h038, 8'ha0 | ch);
            wait_irq(1400);
            chk(n, (39 << i) + 1);
            chk(dac_code, levels[8 * ch - 1 -: 8]);
            chk(lad, 1);
            chk(chan_enable, 1 << (ch - 1));
            rd(12'h038, 8'h20 | ch, 8'hff);
            chk(ladder_connect, 0);
            rd(12'h080, 8'h20, 8'hff);
            rd(12'h07c, levels[8 * ch - 1 -: 8], 8'hff);
            rd(12'h080, 8'h00, 8'hff);
        end
        apb(1, 12'h03c, 8'h30);
        repeat (2) @(posedge sys_clk);
        chk(ladder_connect, 1);
        apb(1, 12'h03c, 8'h12);
        apb(1, 12'h038, 8'ha1);
        wait_irq(1400);
        chk(n, 0);
        apb(1, 12'h03c, 8'h16);
        apb(1, 12'h038, 8'hb1);
        rd(12'h080, 8'h00, 8'hff);
        chk(chan_enable, 0);
        apb(1, 12'h038, 8'ha1);
        rd(12'h080, 8'h10, 8'hff);
        @(posedge sys_clk);
        low_power <= 1;
        repeat (3) @(posedge sys_clk);
        apb(1, 12'h038, 8'h21);
        rd(12'h038, 8'h10, 8'hff);
        rd(12'h03c, 8'h00, 8'h3f);
        rd(12'h080, 8'h00, 8'hff);
        low_power <= 0;
        wait_irq(200);
        chk(n, 0);
        results;
    end
endmodule
bind sac_top sac_top_props #(.RES_W(RES_W), .CHAN_N(CHAN_N)) u_props (.sys_clk(sys_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power(low_power), .cmp_in(cmp_in), .dac_code(dac_code),
    .ladder_connect(ladder_connect), .chan_enable(chan_enable),
    .conversion_done_irq(conversion_done_irq));
